// file: design/ssd_pkg.sv
// package: encodings, field positions, reset values and bus map of the executor
package ssd_pkg;

    // instruction word geometry
    localparam int        OP_W           = 12;
    localparam int        DATA_W         = 8;
    localparam int        FADDR_W        = 5;
    localparam int        DEST_BIT       = 5;
    localparam int        SEL_W          = 3;

    // opcode patterns: upper six bits for the two file ops, upper nine for direction load
    localparam logic [5:0] OPC_SUB       = 6'h02;
    localparam logic [5:0] OPC_SWAP      = 6'h0E;
    localparam logic [8:0] OPC_DIRLOAD   = 9'h000;

    // valid direction register selectors
    localparam logic [2:0] SEL_DIR_FIRST = 3'h5;
    localparam logic [2:0] SEL_DIR_LAST  = 3'h7;
    localparam int         NUM_DIR       = 3;

    // reset values
    localparam logic [7:0] WORK_RST      = 8'h00;
    localparam logic [7:0] DIR_RST       = 8'hFF;
    localparam logic [2:0] STATUS_RST    = 3'h0;

    // status bit positions
    localparam int        ST_CARRY       = 0;
    localparam int        ST_HALF        = 1;
    localparam int        ST_ZERO        = 2;

    // register bus map (byte offsets)
    localparam int        ADDR_W         = 8;
    localparam logic [7:0] OFF_WORK      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_DIR5      = 8'h08;
    localparam logic [7:0] OFF_DIR6      = 8'h0C;
    localparam logic [7:0] OFF_DIR7      = 8'h10;
    localparam logic [7:0] OFF_LASTOP    = 8'h14;
    localparam logic [7:0] OFF_FILE_BASE = 8'h80;

    // operation decoded from an instruction word
    typedef enum logic [1:0]
    {
        SSD_OP_NONE = 2'b00,
        SSD_OP_SUB  = 2'b01,
        SSD_OP_SWAP = 2'b10,
        SSD_OP_DIR  = 2'b11
    } ssd_op_e;

    // instruction issue bundle
    typedef struct packed
    {
        logic              valid;
        logic [OP_W-1:0]   word;
    } ssd_instr_s;

    // register bus request bundle
    typedef struct packed
    {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } ssd_bus_s;

endpackage : ssd_pkg

// file: design/ssd_file_mem.sv
// file register memory: 32 bytes, one write port, registered read port
`timescale 1ns/100ps
module ssd_file_mem
(
    input  wire logic                        clk,
    input  wire logic                        we,
    input  wire logic [ssd_pkg::FADDR_W-1:0] waddr,
    input  wire logic [ssd_pkg::DATA_W-1:0]  wdata,
    input  wire logic [ssd_pkg::FADDR_W-1:0] raddr,
    output logic      [ssd_pkg::DATA_W-1:0]  rdata
);
    import ssd_pkg::*;

    logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

    // write then registered read
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : ssd_file_mem

// file: design/ssd_exec.sv
// executor for subtract, nibble exchange and pin direction load instructions
//
// What this block does
// - subtract: file value minus working value
// - dest zero: difference to working register only
// - nibble exchange swaps halves, flags untouched
// - exchange dest bit: zero work, one file
// - direction load copies work; selectors 5-7 only
//
// an instruction is accepted when instr.valid is high and the block is idle;
// subtract and exchange read the file operand one cycle, then write back the next cycle.
//
// timing, counted from the edge that takes an instruction:
//   subtract and exchange: read cycle, write cycle, done one cycle later
//   direction load: write cycle only, done one cycle later
//   unknown word: illegal pulse the next cycle, no done, block stays idle
//   bad direction selector: no write, illegal and done pulse together
//   a new instruction may be taken in the cycle done is high
//
// hazards and limits:
//   the file memory is not reset; write a location before using it
//   an executing write-back beats a bus write in the same cycle
//   a bus read of a file register during execution may return the operand
//   instr_ready is combinational and low from take to write-back
//   direction registers are read only on the bus
//   direction registers reset to all ones, every pin an input
//   half carry means no borrow out of the low nibble
//   results stand until an instruction or a bus write changes them
//   bus read data stand only in the cycle after the read strobe
//   the last executed word reads back for debug
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
module ssd_exec
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire ssd_pkg::ssd_instr_s         instr,
    output logic                             instr_ready,
    output logic                             done,
    output logic                             illegal,
    input  wire ssd_pkg::ssd_bus_s           bus,
    output logic      [31:0]                 rdata,
    output logic      [ssd_pkg::DATA_W-1:0]  work_out,
    output logic      [ssd_pkg::DATA_W-1:0]  dir5_out,
    output logic      [ssd_pkg::DATA_W-1:0]  dir6_out,
    output logic      [ssd_pkg::DATA_W-1:0]  dir7_out,
    output logic      [2:0]                  status_out
);
    import ssd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode helper
    // opcode match on upper bits; any other word is left undecoded
    function automatic ssd_op_e decode_op(input logic [OP_W-1:0] w);
        ssd_op_e r;
        r = SSD_OP_NONE;
        if (w[11:6] == OPC_SUB)
            r = SSD_OP_SUB;
        else if (w[11:6] == OPC_SWAP)
            r = SSD_OP_SWAP;
        else if (w[11:3] == OPC_DIRLOAD)
            r = SSD_OP_DIR;
        return r;
    endfunction : decode_op

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } ssd_state_e;

    // sequencer, captured word and architectural registers
    ssd_state_e            state_reg;
    ssd_state_e            state_next;
    ssd_op_e               op_reg;
    logic [OP_W-1:0]       word_reg;
    logic [DATA_W-1:0]     work_reg;
    logic [DATA_W-1:0]     dir_reg [0:NUM_DIR-1];
    logic [2:0]            status_reg;
    logic [OP_W-1:0]       lastop_reg;
    logic                  done_reg;
    logic                  illegal_reg;
    logic                  bus_file_reg;
    logic [31:0]           rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // decode of the accepted instruction
    wire                   accept     = instr.valid && (state_reg == ST_IDLE);
    wire ssd_op_e          new_op     = decode_op(instr.word);
    wire                   dest_file  = word_reg[DEST_BIT];
    wire [FADDR_W-1:0]     faddr      = word_reg[FADDR_W-1:0];
    // selector is the low three bits; only five to seven name a register
    wire [SEL_W-1:0]       dir_sel    = word_reg[SEL_W-1:0];
    wire                   dir_valid  = (dir_sel >= SEL_DIR_FIRST)
                                        && (dir_sel <= SEL_DIR_LAST);
    wire [1:0]             dir_idx    = 2'(dir_sel - SEL_DIR_FIRST);

    ////////////////////////////////////////////////////////////////////////
    // file memory, shared by instruction and bus
    wire [DATA_W-1:0]      file_val;
    wire                   bus_file   = bus.addr >= OFF_FILE_BASE;
    wire [FADDR_W-1:0]     bus_faddr  = bus.addr[FADDR_W+1:2];
    wire                   ex_write   = (state_reg == ST_WRITE)
                                        && (op_reg != SSD_OP_DIR) && dest_file;
    // a bus file write loses to the executing write-back
    wire                   bus_fwr    = bus.wr && bus_file && !ex_write;
    // operand address from the offered word at take and from the captured
    // word in the read cycle, so the write cycle sees the right byte
    wire [FADDR_W-1:0]     mem_raddr  = accept ? instr.word[FADDR_W-1:0]
                                        : (state_reg == ST_READ) ? faddr
                                        : bus_faddr;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic: file minus work, borrow-free carry
    wire [DATA_W:0]        diff_full  = {1'b0, file_val} - {1'b0, work_reg};
    wire [DATA_W-1:0]      diff       = diff_full[DATA_W-1:0];
    // carry and half carry report that no borrow occurred
    wire                   carry_nb   = (file_val >= work_reg);
    wire                   half_nb    = (file_val[3:0] >= work_reg[3:0]);
    wire                   zero_res   = (diff == 8'h00);
    wire [DATA_W-1:0]      swapped    = {file_val[3:0], file_val[7:4]};
    // difference for subtract, exchanged nibbles otherwise
    wire [DATA_W-1:0]      result     = (op_reg == SSD_OP_SUB) ? diff : swapped;
    wire [DATA_W-1:0]      mem_wdata  = ex_write ? result : bus.wdata[DATA_W-1:0];
    wire [FADDR_W-1:0]     mem_waddr  = ex_write ? faddr : bus_faddr;

    // one shared memory; the executing write-back has priority
    ssd_file_mem u_file_mem
    (
        .clk   (clk),
        .we    (ex_write || bus_fwr),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (file_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing: direction load needs no file read
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept)
                    state_next = (new_op == SSD_OP_DIR) ? ST_WRITE : ST_READ;
            end
            ST_READ:  state_next = ST_WRITE;
            ST_WRITE: state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    // state register and op capture; unknown words finish flagged illegal
    // an unknown word is refused and the block stays idle for the next one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            op_reg    <= SSD_OP_NONE;
            word_reg  <= '0;
        end
        else if (accept && new_op == SSD_OP_NONE)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
            if (accept)
            begin
                op_reg   <= new_op;
                word_reg <= instr.word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working register: executed result wins over a bus write
    // a bus write to work beside a write-back to work is dropped
    wire                   work_ex    = (state_reg == ST_WRITE) && !dest_file
                                        && (op_reg != SSD_OP_DIR);
    wire                   bus_work   = bus.wr && (bus.addr == OFF_WORK);

    always_ff @(posedge clk)
    begin
        if (rst)
            work_reg <= WORK_RST;
        else if (work_ex)
            work_reg <= result;
        else if (bus_work)
            work_reg <= bus.wdata[DATA_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags: of the instructions only subtract changes them; a bus write to status also does
    // a bus write to status beside a subtract write-back is dropped
    wire                   flag_ex    = (state_reg == ST_WRITE) && (op_reg == SSD_OP_SUB);
    wire                   bus_stat   = bus.wr && (bus.addr == OFF_STATUS);

    always_ff @(posedge clk)
    begin
        if (rst)
            status_reg <= STATUS_RST;
        else if (flag_ex)
        begin
            status_reg[ST_CARRY] <= carry_nb;
            status_reg[ST_HALF]  <= half_nb;
            status_reg[ST_ZERO]  <= zero_res;
        end
        else if (bus_stat)
            status_reg <= bus.wdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // direction registers loaded from work on a valid selector
    // a bad selector writes nothing; the illegal pulse below reports it
    wire                   dir_ex     = (state_reg == ST_WRITE) && (op_reg == SSD_OP_DIR);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_DIR; i++)
                dir_reg[i] <= DIR_RST;
        end
        else if (dir_ex && dir_valid)
            dir_reg[dir_idx] <= work_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // completion pulse, illegal pulse and last executed word
    // done follows every write cycle, illegal a refused word or selector
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            lastop_reg  <= '0;
        end
        else
        begin
            done_reg    <= (state_reg == ST_WRITE);
            illegal_reg <= (accept && new_op == SSD_OP_NONE)
                           || (dir_ex && !dir_valid);
            if (state_reg == ST_WRITE)
                lastop_reg <= word_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus read mux; file reads come out of the memory register one cycle later
    // unmapped addresses read as zero
    logic [31:0] reg_rd;

    always_comb
    begin
        case (bus.addr)
            OFF_WORK:   reg_rd = {24'h000000, work_reg};
            OFF_STATUS: reg_rd = {29'h00000000, status_reg};
            OFF_DIR5:   reg_rd = {24'h000000, dir_reg[0]};
            OFF_DIR6:   reg_rd = {24'h000000, dir_reg[1]};
            OFF_DIR7:   reg_rd = {24'h000000, dir_reg[2]};
            OFF_LASTOP: reg_rd = {20'h00000, lastop_reg};
            default:    reg_rd = 32'h00000000;
        endcase
    end

    // read data register
    // rdata_reg is zero outside the cycle after a read strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_reg    <= 32'h00000000;
            bus_file_reg <= 1'b0;
        end
        else
        begin
            rdata_reg    <= bus.rd ? reg_rd : 32'h00000000;
            bus_file_reg <= bus.rd && bus_file;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // file reads take the byte straight from the memory's read register
    assign rdata       = bus_file_reg ? {24'h000000, file_val} : rdata_reg;
    assign instr_ready = (state_reg == ST_IDLE);
    assign done        = done_reg;
    assign illegal     = illegal_reg;
    assign work_out    = work_reg;
    assign dir5_out    = dir_reg[0];
    assign dir6_out    = dir_reg[1];
    assign dir7_out    = dir_reg[2];
    assign status_out  = status_reg;

endmodule : ssd_exec

// file: sim/ssd_exec_checker.sv
// checker: timing and flag relations of the instruction executor
`timescale 1ns/100ps
module ssd_exec_checker
(
    input wire logic               clk,
    input wire logic               rst,
    input wire ssd_pkg::ssd_instr_s instr,
    input wire logic               instr_ready,
    input wire logic               done,
    input wire logic               illegal,
    input wire logic [7:0]         work_out,
    input wire logic [7:0]         dir5_out,
    input wire logic [7:0]         dir6_out,
    input wire logic [7:0]         dir7_out,
    input wire logic [2:0]         status_out
);
    import ssd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // decode of the accepted word
    wire       take   = instr.valid && instr_ready;
    wire       op_sub = take && instr.word[11:6] == OPC_SUB;
    wire       op_swp = take && instr.word[11:6] == OPC_SWAP;
    wire       op_dir = take && instr.word[11:3] == OPC_DIRLOAD;
    wire       dest   = instr.word[DEST_BIT];
    logic       sub_reg;
    logic       d_reg;
    logic [2:0] sel_reg;
    // remember what the last accepted word asked for
    always_ff @(posedge clk)
        if (take)
        begin
            sub_reg <= op_sub;
            d_reg   <= dest;
            sel_reg <= instr.word[2:0];
        end
    // direction register addressed by the last selector
    wire [7:0] dir_pick = (sel_reg == 3'h5) ? dir5_out : (sel_reg == 3'h6) ? dir6_out : dir7_out;
    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_sub_done_time: assert property (op_sub |-> ##1 !done[*2] ##1 done)
        else $error("subtract did not finish on time");
    a_sub_work_kept: assert property (op_sub && dest |=> $stable(work_out)[*3])
        else $error("subtract to file changed work");
    a_sub_zero_dest: assert property (done && sub_reg && !d_reg && status_out[ST_ZERO]
        |-> work_out == 8'h00) else $error("zero flag without zero work");
    a_sub_zero_carry: assert property (done && sub_reg && status_out[ST_ZERO]
        |-> status_out[ST_CARRY] && status_out[ST_HALF]) else $error("zero result borrowed");
    a_swap_flags_kept: assert property (op_swp |=> $stable(status_out)[*3])
        else $error("exchange altered flags");
    a_swap_work_kept: assert property (op_swp && dest |=> $stable(work_out)[*3])
        else $error("exchange to file changed work");
    a_dir_copy_work: assert property (op_dir && instr.word[2:0] >= SEL_DIR_FIRST
        |-> ##2 done && dir_pick == $past(work_out, 2)) else $error("direction load wrong");
    a_dir_bad_sel: assert property (op_dir && instr.word[2:0] < SEL_DIR_FIRST
        |-> ##2 illegal && done && {dir5_out, dir6_out, dir7_out} == $past({dir5_out,
        dir6_out, dir7_out}, 2)) else $error("bad selector not refused");
    // main scenarios reached
    c_sub_work: cover property (op_sub && !dest);
    c_swap_file: cover property (op_swp && dest);
    c_dir_bad: cover property (illegal);
endmodule : ssd_exec_checker
bind ssd_exec ssd_exec_checker u_chk (.clk, .rst, .instr, .instr_ready, .done, .illegal,
    .work_out, .dir5_out, .dir6_out, .dir7_out, .status_out);

// file: sim/subtract_swap_dirload_exec_test.sv
// testbench: random subtract, exchange and direction loads against a model
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module subtract_swap_dirload_exec_test;
    import ssd_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    ssd_instr_s  instr = '0;
    ssd_bus_s    bus = '0;
    logic [31:0] rdata;
    logic        instr_ready;
    logic        done;
    logic        illegal;
    logic        bad;
    logic [7:0]  work_out;
    logic [7:0]  dir5_out;
    logic [7:0]  dir6_out;
    logic [7:0]  dir7_out;
    logic [2:0]  status_out;
    logic [11:0] wd;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          seed = 28;
    int          m_w, m_st, m_f[32], m_d[3] = '{255, 255, 255};
    int          a, fv, r, d, s, op;
    ssd_exec u_dut (.clk, .rst, .instr, .instr_ready, .done, .illegal, .bus, .rdata,
        .work_out, .dir5_out, .dir6_out, .dir7_out, .status_out);
    // clock
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
        end
    endtask : chk
    // one-cycle bus write
    task automatic wr(input logic [7:0] ad, input int dt);
        @(posedge clk) bus <= {2'b10, ad, 32'(dt)};
        @(posedge clk) bus.wr <= 1'b0;
    endtask : wr
    // one-cycle bus read, data checked in the following cycle
    task automatic rd(input logic [7:0] ad, input int e);
        @(posedge clk) bus <= {2'b01, ad, 32'h0};
        @(posedge clk) bus.rd <= 1'b0;
        @(negedge clk) `CHK(rdata, e);
    endtask : rd
    // offer one word, wait a bounded time for done or illegal
    task automatic ex(input logic [11:0] w, output logic b);
        @(posedge clk) instr <= {1'b1, w};
        @(posedge clk) instr.valid <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            if ((done | illegal) === 1'b1) break;
            if (i == 7) n_mismatch++;
            if (i == 7) end_of_test();
        end
        b = illegal;
    endtask : ex
    // counts and verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK({work_out, status_out}, 0);
        `CHK({dir5_out, dir6_out, dir7_out}, 24'hFFFFFF);
        rd(8'h44, 0);
        $display("test reset done");
        for (int i = 0; i < 90; i++)
        begin
            op = i % 3;
            a = $random(seed) & 31;
            m_w = $random(seed) & 255;
            fv = (i % 4 == 0) ? m_w : $random(seed) & 255;
            d = $random(seed) & 1;
            s = $random(seed) & 7;
            // work last, so the idle bus address no longer names the operand
            wr(OFF_FILE_BASE + 8'(4 * a), fv);
            wr(OFF_WORK, m_w);
            m_f[a] = fv;
            wd = (op == 0) ? {OPC_SUB, 1'(d), 5'(a)} : (op == 1) ? {OPC_SWAP, 1'(d), 5'(a)}
                : {OPC_DIRLOAD, 3'(s)};
            ex(wd, bad);
            r = (op == 0) ? (fv - m_w) & 255 : ((fv & 15) << 4) | (fv >> 4);
            if (op == 0)
                m_st = int'(fv >= m_w) | int'(fv % 16 >= m_w % 16) << 1 | int'(r == 0) << 2;
            if (op < 2 && d == 1)
                m_f[a] = r;
            if (op < 2 && d == 0)
                m_w = r;
            if (op == 2 && s >= 5)
                m_d[s - 5] = m_w;
            `CHK(bad, op == 2 && s < 5);
            `CHK(work_out, m_w);
            `CHK(status_out, m_st);
            rd(OFF_FILE_BASE + 8'(4 * a), m_f[a]);
            rd(OFF_WORK, m_w);
            `CHK({dir5_out, dir6_out, dir7_out}, m_d[0] << 16 | m_d[1] << 8 | m_d[2]);
        end
        $display("test random ops done");
        ex(12'hFFF, bad);
        `CHK(bad, 1);
        `CHK(work_out, m_w);
        $display("test unknown word done");
        end_of_test();
    end
endmodule : subtract_swap_dirload_exec_test
